//--- rrx_pkg.sv
// package for the return and rotate execution block
// assumes a core that presents one decoded operation per instruction cycle
// Function
// - interrupt return pops stack into program counter; one word, two cycles
// - interrupt return sets global interrupt enable, bit 7 of interrupt control
// - literal return writes 8-bit literal into working register, flags untouched
// - literal return also pops stack into program counter; two cycles
// - subroutine return pops stack into program counter, no flags, two cycles
// - rotate left: old bit 7 to carry, old carry into bit 0
// - destination select 0 writes working register, 1 writes source register 0..127
// - rotate changes only carry, one word, one cycle
package rrx_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PC_W      = 15;
  localparam int unsigned FADDR_W   = 7;
  localparam int unsigned GIE_BIT   = 7;
  localparam int unsigned MSB_BIT   = 7;
  localparam int unsigned RET_CYC   = 2;
  localparam logic        DEST_W    = 1'h0;
  localparam logic        DEST_F    = 1'h1;
  localparam logic [7:0]  WREG_RST  = 8'h00;
  localparam logic [14:0] PC_RST    = 15'h0000;

  typedef enum logic [1:0] {
    RRX_OP_NONE,
    RRX_OP_RETI,
    RRX_OP_RETLIT,
    RRX_OP_RETSUB
  } rrx_ret_t;

  typedef enum {
    RRX_EXEC,
    RRX_FLUSH
  } rrx_state_t;
endpackage : rrx_pkg

//--- rrx_exec.sv
// execution unit for interrupt, literal and subroutine returns and rotate left through carry
// assumes the decoder presents an op only in cycles where busy is low; stack top is valid on request
`timescale 1ns/100ps
`default_nettype none
module rrx_exec
  import rrx_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               returnFromInterruptOp,
  input  wire logic               returnWithLiteralOp,
  input  wire logic               returnSubOp,
  input  wire logic               rotateLeftCarryOp,
  input  wire logic [7:0]         literalOperand,
  input  wire logic [6:0]         fileRegisterOperand,
  input  wire logic               destinationSelect,
  input  wire logic [7:0]         fileReadData,
  input  wire logic [14:0]        topOfStack,
  input  wire logic [7:0]         interruptControlIn,
  output var  logic [14:0]        programCounter,
  output var  logic               pcLoad,
  output var  logic               stackPop,
  output var  logic [7:0]         workingRegister,
  output var  logic               carryFlag,
  output var  logic               fileWrite,
  output var  logic [6:0]         fileWriteAddr,
  output var  logic [7:0]         fileWriteData,
  output var  logic               interruptControlWrite,
  output var  logic [7:0]         interruptControlOut,
  output var  logic               flushFetch,
  output var  logic               busy
);
  rrx_state_t state;
  rrx_state_t next_state;

  // a return is accepted only in execute state so a second op cannot overlap the flush cycle
  wire logic       inExec   = (state == RRX_EXEC);
  wire logic       anyRet   = inExec & (returnFromInterruptOp | returnWithLiteralOp | returnSubOp);
  wire logic       doRotate = inExec & rotateLeftCarryOp & ~anyRet;
  wire logic [7:0] rotated  = {fileReadData[MSB_BIT-1:0], carryFlag};
  wire logic [7:0] next_icon;

  assign next_icon = interruptControlIn | (8'h01 << GIE_BIT);

  always_comb
  begin
    next_state = state;
    unique case (state)
      RRX_EXEC:  if (anyRet) next_state = RRX_FLUSH;
      RRX_FLUSH: next_state = RRX_EXEC;
    endcase
  end

  // named strobes keep the register blocks short and match the checks below
  wire logic       takeIcon = inExec & returnFromInterruptOp;
  wire logic       takeLit  = inExec & returnWithLiteralOp;
  wire logic       rotToW   = doRotate & (destinationSelect == DEST_W);
  wire logic       rotToF   = doRotate & (destinationSelect == DEST_F);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= RRX_EXEC;
    else
      state <= next_state;
  end

  // pop, load and flush are one-cycle pulses in the second return cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pcLoad     <= 1'h0;
      stackPop   <= 1'h0;
      flushFetch <= 1'h0;
      busy       <= 1'h0;
    end
    else
    begin
      pcLoad     <= anyRet;
      stackPop   <= anyRet;
      flushFetch <= anyRet;
      busy       <= anyRet;
    end
  end

  // pc holds between returns; the fetch side advances it for ordinary ops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      programCounter <= PC_RST;
    else if (anyRet)
      programCounter <= topOfStack;
  end

  // read-modify-write of interrupt control; only the enable bit is forced
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      interruptControlWrite <= 1'h0;
      interruptControlOut   <= 8'h00;
    end
    else
    begin
      interruptControlWrite <= takeIcon;
      if (takeIcon)
        interruptControlOut <= next_icon;
    end
  end

  // literal return and rotate to w never coincide: returns take priority
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      workingRegister <= WREG_RST;
    else if (takeLit)
      workingRegister <= literalOperand;
    else if (rotToW)
      workingRegister <= rotated;
  end

  // returns leave carry alone; only a rotate touches carry
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      carryFlag <= 1'h0;
    else if (doRotate)
      carryFlag <= fileReadData[MSB_BIT];
  end

  // address and data follow every cycle to save muxing; only the strobe qualifies them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fileWrite     <= 1'h0;
      fileWriteAddr <= 7'h00;
      fileWriteData <= 8'h00;
    end
    else
    begin
      fileWrite     <= rotToF;
      fileWriteAddr <= fileRegisterOperand;
      fileWriteData <= rotated;
    end
  end

  chk_ret_pop_pc: assert property (@(posedge clk) disable iff (!arst_n)
    anyRet |=> pcLoad && stackPop && programCounter == $past(topOfStack))
    else $error("return did not load pc from stack");
  chk_gie_set: assert property (@(posedge clk) disable iff (!arst_n)
    (inExec && returnFromInterruptOp) |=> interruptControlWrite && interruptControlOut[GIE_BIT])
    else $error("interrupt return did not set global enable");
  chk_lit_wreg: assert property (@(posedge clk) disable iff (!arst_n)
    (inExec && returnWithLiteralOp) |=> workingRegister == $past(literalOperand) && $stable(carryFlag))
    else $error("literal return wrong working register or flag");
  chk_ret_two_cyc: assert property (@(posedge clk) disable iff (!arst_n)
    anyRet |=> busy ##1 (!busy && state == RRX_EXEC))
    else $error("return not two cycles");
  chk_sub_noflag: assert property (@(posedge clk) disable iff (!arst_n)
    (inExec && returnSubOp) |=> $stable(carryFlag) && !fileWrite)
    else $error("subroutine return touched flags");
  chk_rot_carry: assert property (@(posedge clk) disable iff (!arst_n)
    doRotate |=> carryFlag == $past(fileReadData[7]) && fileWriteData[0] == $past(carryFlag))
    else $error("rotate carry path wrong");
  chk_rot_dest: assert property (@(posedge clk) disable iff (!arst_n)
    doRotate |=> fileWrite == $past(destinationSelect) && fileWriteAddr == $past(fileRegisterOperand))
    else $error("rotate destination wrong");
  chk_rot_one_cyc: assert property (@(posedge clk) disable iff (!arst_n)
    doRotate |=> !busy && !pcLoad && state == RRX_EXEC)
    else $error("rotate not single cycle");
  // the interrupt control pulse of the return itself stands in the flush cycle
  chk_flush_nop: assert property (@(posedge clk) disable iff (!arst_n)
    (state == RRX_FLUSH) |-> (flushFetch && !fileWrite) ##1 (!flushFetch && !interruptControlWrite && !fileWrite))
    else $error("flush cycle not a no-operation");

  chk_busy_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    busy |=> !pcLoad && !fileWrite && !interruptControlWrite)
    else $error("op taken while busy");

  chk_pop_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    pcLoad |=> !pcLoad && !stackPop)
    else $error("pop pulse longer than one cycle");

  chk_pc_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !anyRet |=> $stable(programCounter))
    else $error("pc changed without a return");

  chk_icon_copy: assert property (@(posedge clk) disable iff (!arst_n)
    takeIcon |=> interruptControlOut[6:0] == $past(interruptControlIn[6:0]))
    else $error("interrupt control bits other than enable changed");

  chk_ret_wreg_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (inExec && (returnFromInterruptOp || returnSubOp)) |=> $stable(workingRegister))
    else $error("return without literal changed working register");

  chk_rot_fdata: assert property (@(posedge clk) disable iff (!arst_n)
    doRotate |=> fileWriteData == {$past(fileReadData[6:0]), $past(carryFlag)})
    else $error("rotate result wrong");

  chk_rot_wreg: assert property (@(posedge clk) disable iff (!arst_n)
    rotToW |=> workingRegister == $past(rotated) && !fileWrite)
    else $error("rotate to working register wrong");

  chk_rot_fkeep: assert property (@(posedge clk) disable iff (!arst_n)
    rotToF |=> $stable(workingRegister) && fileWrite)
    else $error("rotate to file touched working register");

  chk_carry_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !doRotate |=> $stable(carryFlag))
    else $error("carry changed without a rotate");
endmodule : rrx_exec
`default_nettype wire

//--- return_and_rotate_instructions_bench.sv
// bench for rrx_exec: random returns and rotates checked against an integer model
// assumes ops are one-cycle pulses and nothing is taken while busy is high
`timescale 1ns/100ps
`default_nettype none
module return_and_rotate_instructions_bench;
  import rrx_pkg::*;
  logic        clk = 0, arst_n = 0, rfi = 0, rlw = 0, rsb = 0, rot = 0, dsel = 0, mC = 0;
  logic [7:0]  lit = 0, frd = 0, icIn = 0, lf = 8'h1c, mW = 0, res, wreg, icOut, fwd;
  logic [6:0]  fadr = 0, fwa;
  logic [14:0] top_of_stack = 0, pc;
  logic        pcl, pop, cy, fw, icw, flu, busy;
  int          errorCnt = 0, nTests = 0, cyc = 0, k;
  always #2 clk = ~clk;
  rrx_exec u_dut (.clk(clk), .arst_n(arst_n), .returnFromInterruptOp(rfi), .returnWithLiteralOp(rlw),
    .returnSubOp(rsb), .rotateLeftCarryOp(rot), .literalOperand(lit), .fileRegisterOperand(fadr),
    .destinationSelect(dsel), .fileReadData(frd), .topOfStack(top_of_stack), .interruptControlIn(icIn),
    .programCounter(pc), .pcLoad(pcl), .stackPop(pop), .workingRegister(wreg), .carryFlag(cy),
    .fileWrite(fw), .fileWriteAddr(fwa), .fileWriteData(fwd), .interruptControlWrite(icw),
    .interruptControlOut(icOut), .flushFetch(flu), .busy(busy));
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic endSim;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : endSim
  // ceiling well above the 600 cycles the loop needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      errorCnt++;
      endSim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    chk({pc[6:0], wreg}, 15'h0000);
    arst_n <= 1;
    repeat (200)
    begin
      @(posedge clk);
      lf = nxt(lf);
      k = lf[1:0];
      rfi <= k == 0;
      rlw <= k == 1;
      rsb <= k == 2;
      rot <= k == 3;
      dsel <= lf[2];
      fadr <= lf[6:0];
      lf = nxt(lf);
      lit <= lf;
      top_of_stack <= {lf[6:0], nxt(lf)};
      lf = nxt(nxt(lf));
      frd <= lf;
      icIn <= {lf[0], lf[7:1]};
      @(posedge clk);
      rfi <= 0;
      rlw <= 0;
      rsb <= 0;
      // a rotate offered in the busy cycle must be dropped
      rot <= k < 3;
      #1;
      res = {frd[6:0], mC};
      if (k == 1) mW = lit;
      if (k == 3 && !dsel) mW = res;
      if (k == 3) mC = frd[7];
      chk({pcl, pop, flu, busy}, {4{k < 3}});
      if (k < 3) chk(pc, top_of_stack);
      chk(icw, k == 0);
      if (k == 0) chk(icOut, icIn | 8'h80);
      chk({cy, wreg}, {mC, mW});
      chk(fw, k == 3 && dsel);
      if (k == 3 && dsel) chk({fwa, fwd}, {fadr, res});
      if (k < 3)
      begin
        @(posedge clk);
        rot <= 0;
        #1;
        chk({busy, flu, cy, wreg}, {2'h0, mC, mW});
      end
    end
    endSim();
  end
endmodule : return_and_rotate_instructions_bench
`default_nettype wire
